// >>> logic/pxc_pkg.sv
// constants and types for the extended control and status register bank
package pxc_pkg;
  // register numbers on the management bus
  localparam logic [4:0] REG_NP_ABILITY = 5'h08;
  localparam logic [4:0] REG_RSV_LO = 5'h09;
  localparam logic [4:0] REG_RSV_HI = 5'h0f;
  localparam logic [4:0] REG_EXT_CTRL = 5'h10;
  localparam logic [4:0] REG_QP_STATUS = 5'h11;
  // extended control field positions
  localparam int CTL_OVR_WE_BIT = 15;
  localparam int CTL_ADDR_HI = 10;
  localparam int CTL_ADDR_LO = 6;
  localparam int CTL_SCR_TEST_BIT = 5;
  localparam int CTL_NRZI_BIT = 3;
  localparam int CTL_TX_INVAL_BIT = 2;
  localparam int CTL_SCR_DIS_BIT = 0;
  // quick poll status field positions
  localparam int ST_RATE_BIT = 15;
  localparam int ST_DUPLEX_BIT = 14;
  localparam int ST_ANP_HI = 13;
  localparam int ST_ANP_LO = 11;
  // reset values
  localparam logic RST_OVR_WE = 1'b0;
  localparam logic RST_SCR_TEST = 1'b0;
  localparam logic RST_NRZI = 1'b1;
  localparam logic RST_TX_INVAL = 1'b0;
  localparam logic RST_SCR_DIS = 1'b0;
  localparam logic [3:0] RST_NP_CODE = 4'h0;
  localparam logic [2:0] RST_ANP = 3'h0;
  localparam logic [1:0] ADDR_HI_ZERO = 2'h0;
  // management frame layout
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [3:0] HDR_LAST = 4'hc;
  localparam logic [3:0] DATA_LAST = 4'hf;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  typedef enum logic [4:0] {
    S_PRE = 5'h01,
    S_HDR = 5'h02,
    S_TA = 5'h04,
    S_RDATA = 5'h08,
    S_WDATA = 5'h10
  } pxc_mdio_state_t;
endpackage

// >>> logic/pxc_ext_regs.sv
// management-bus slave with the extended control and quick poll status registers
`timescale 1ns/1ps
`default_nettype none
module pxc_ext_regs (
  input wire logic ref_clk_in,              // 125 MHz clock
  input wire logic rst_in,                  // sync reset, active high
  input wire logic mdc_in,                  // management clock pin
  input wire logic mdio_in,                 // management data pin, input side
  output logic mdio_out,                    // management data, output side
  output logic mdio_oe_n_out,               // low while driving management data
  input wire logic [3:0] np_code_in,        // received next-page code bits
  input wire logic np_page_valid_in,        // pulse: new partner page received
  input wire logic [2:0] phy_addr_strap_in, // address straps
  input wire logic speed_100_in,            // current rate is 100 Mbps
  input wire logic full_duplex_in,          // current duplex is full
  input wire logic [2:0] an_progress_in,    // current negotiation progress code
  output logic override_we_out,             // one-cycle override write enable
  output logic scr_test_out,                // scrambler test mode
  output logic nrzi_sel_out,                // 1 = nrzi, 0 = nrz
  output logic tx_invalid_en_out,           // allow invalid code groups
  output logic scr_disable_out,             // bypass scrambler
  output logic [4:0] phy_addr_out           // management address in use
);

  function automatic logic is_reserved(input logic [4:0] ra);
    is_reserved = (ra >= pxc_pkg::REG_RSV_LO) && (ra <= pxc_pkg::REG_RSV_HI);
  endfunction

  logic [2:0] mdc_sync_ff, mdio_sync_ff;
  logic mdc_lvl_ff, mdio_lvl_ff;
  logic mdc_rise;
  pxc_pkg::pxc_mdio_state_t state_ff;
  logic [5:0] ones_ff;
  logic [3:0] cnt_ff;
  logic [12:0] hdr_ff;
  logic [15:0] rd_sr_ff, wd_sr_ff;
  logic strap_pend_ff;
  logic [2:0] strap_ff;
  logic [3:0] np_ff;
  logic [2:0] anp_ff;
  logic ovr_we_ff, scr_test_ff, nrzi_ff, tx_inval_ff, scr_dis_ff;
  logic [4:0] hdr_reg, hdr_phy;
  logic [1:0] hdr_op;
  logic frame_ok, rd_load, wr_commit, rd_done17;
  logic [15:0] wr_data, ctl_rd, st_rd, rd_val;

  // three-stage pin synchronisers; a change counts when stages two and three agree
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mdc_sync_ff <= 3'h0;
      mdio_sync_ff <= 3'h0;
      mdc_lvl_ff <= 1'b0;
      mdio_lvl_ff <= 1'b0;
    end else begin
      mdc_sync_ff <= {mdc_sync_ff[1:0], mdc_in};
      mdio_sync_ff <= {mdio_sync_ff[1:0], mdio_in};
      if (mdc_sync_ff[1] == mdc_sync_ff[2])
        mdc_lvl_ff <= mdc_sync_ff[2];
      if (mdio_sync_ff[1] == mdio_sync_ff[2])
        mdio_lvl_ff <= mdio_sync_ff[2];
    end
  end

  assign mdc_rise = mdc_sync_ff[1] & mdc_sync_ff[2] & ~mdc_lvl_ff;
  assign hdr_reg = hdr_ff[4:0];
  assign hdr_phy = hdr_ff[9:5];
  assign hdr_op = hdr_ff[11:10];
  assign frame_ok = hdr_ff[12] && (hdr_phy == phy_addr_out);
  assign rd_load = mdc_rise && (state_ff == pxc_pkg::S_TA) && (cnt_ff == 4'h0)
                   && frame_ok && (hdr_op == pxc_pkg::OP_READ);
  assign wr_data = {wd_sr_ff[14:0], mdio_lvl_ff};
  assign wr_commit = mdc_rise && (state_ff == pxc_pkg::S_WDATA) && (cnt_ff == pxc_pkg::DATA_LAST);
  assign rd_done17 = mdc_rise && (state_ff == pxc_pkg::S_RDATA) && (cnt_ff == pxc_pkg::DATA_LAST)
                     && (hdr_reg == pxc_pkg::REG_QP_STATUS);

  // read images; reserved control bits read zero, override reads back its live state
  always_comb begin
    ctl_rd = 16'h0000;
    ctl_rd[pxc_pkg::CTL_OVR_WE_BIT] = ovr_we_ff;
    ctl_rd[pxc_pkg::CTL_ADDR_HI:pxc_pkg::CTL_ADDR_LO] = phy_addr_out;
    ctl_rd[pxc_pkg::CTL_SCR_TEST_BIT] = scr_test_ff;
    ctl_rd[pxc_pkg::CTL_NRZI_BIT] = nrzi_ff;
    ctl_rd[pxc_pkg::CTL_TX_INVAL_BIT] = tx_inval_ff;
    ctl_rd[pxc_pkg::CTL_SCR_DIS_BIT] = scr_dis_ff;
    st_rd = 16'h0000;
    st_rd[pxc_pkg::ST_RATE_BIT] = speed_100_in;
    st_rd[pxc_pkg::ST_DUPLEX_BIT] = full_duplex_in;
    st_rd[pxc_pkg::ST_ANP_HI:pxc_pkg::ST_ANP_LO] = anp_ff;
    rd_val = 16'h0000;
    if (is_reserved(hdr_reg))
      rd_val = 16'h0000;
    else if (hdr_reg == pxc_pkg::REG_NP_ABILITY)
      rd_val = {12'h000, np_ff};
    else if (hdr_reg == pxc_pkg::REG_EXT_CTRL)
      rd_val = ctl_rd;
    else if (hdr_reg == pxc_pkg::REG_QP_STATUS)
      rd_val = st_rd;
  end

  // frame sequencer: preamble, header, turnaround, data
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_ff <= pxc_pkg::S_PRE;
      ones_ff <= 6'h00;
      cnt_ff <= 4'h0;
      hdr_ff <= 13'h0000;
      rd_sr_ff <= 16'h0000;
      wd_sr_ff <= 16'h0000;
    end else if (mdc_rise) begin
      case (state_ff)
        pxc_pkg::S_PRE: begin
          if (mdio_lvl_ff) begin
            if (ones_ff != pxc_pkg::PREAMBLE_LEN)
              ones_ff <= ones_ff + 6'h01;
          end else begin
            ones_ff <= 6'h00;
            cnt_ff <= 4'h0;
            if (ones_ff == pxc_pkg::PREAMBLE_LEN)
              state_ff <= pxc_pkg::S_HDR;
          end
        end
        pxc_pkg::S_HDR: begin
          hdr_ff <= {hdr_ff[11:0], mdio_lvl_ff};
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == pxc_pkg::HDR_LAST) begin
            cnt_ff <= 4'h0;
            state_ff <= pxc_pkg::S_TA;
          end
        end
        pxc_pkg::S_TA: begin
          if (cnt_ff == 4'h0) begin
            cnt_ff <= 4'h1;
            if (rd_load)
              rd_sr_ff <= rd_val;
          end else begin
            cnt_ff <= 4'h0;
            rd_sr_ff <= {rd_sr_ff[14:0], 1'b0};
            if (frame_ok && hdr_op == pxc_pkg::OP_READ)
              state_ff <= pxc_pkg::S_RDATA;
            else if (frame_ok && hdr_op == pxc_pkg::OP_WRITE)
              state_ff <= pxc_pkg::S_WDATA;
            else
              state_ff <= pxc_pkg::S_PRE;
          end
        end
        pxc_pkg::S_RDATA: begin
          cnt_ff <= cnt_ff + 4'h1;
          rd_sr_ff <= {rd_sr_ff[14:0], 1'b0};
          if (cnt_ff == pxc_pkg::DATA_LAST)
            state_ff <= pxc_pkg::S_PRE;
        end
        pxc_pkg::S_WDATA: begin
          cnt_ff <= cnt_ff + 4'h1;
          wd_sr_ff <= wr_data;
          if (cnt_ff == pxc_pkg::DATA_LAST)
            state_ff <= pxc_pkg::S_PRE;
        end
        default: begin
          state_ff <= pxc_pkg::S_PRE;
          cnt_ff <= 4'h0;
        end
      endcase
    end
  end

  // data pin drive; zero in second turnaround bit, then msb first
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mdio_out <= 1'b0;
      mdio_oe_n_out <= 1'b1;
    end else if (mdc_rise) begin
      if (rd_load) begin
        mdio_out <= 1'b0;
        mdio_oe_n_out <= 1'b0;
      end else if (state_ff == pxc_pkg::S_TA && !mdio_oe_n_out) begin
        mdio_out <= rd_sr_ff[15];
      end else if (state_ff == pxc_pkg::S_RDATA && cnt_ff != pxc_pkg::DATA_LAST) begin
        mdio_out <= rd_sr_ff[15];
      end else begin
        mdio_out <= 1'b0;
        mdio_oe_n_out <= 1'b1;
      end
    end
  end

  // straps caught on the first cycle after reset release
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      strap_pend_ff <= 1'b1;
      strap_ff <= 3'h0;
    end else if (strap_pend_ff) begin
      strap_pend_ff <= 1'b0;
      strap_ff <= phy_addr_strap_in;
    end
  end
  assign phy_addr_out = {pxc_pkg::ADDR_HI_ZERO, strap_ff};

  // control register; reserved bits are not stored, so a non-zero write there is harmless
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ovr_we_ff <= pxc_pkg::RST_OVR_WE;
      scr_test_ff <= pxc_pkg::RST_SCR_TEST;
      nrzi_ff <= pxc_pkg::RST_NRZI;
      tx_inval_ff <= pxc_pkg::RST_TX_INVAL;
      scr_dis_ff <= pxc_pkg::RST_SCR_DIS;
    end else begin
      ovr_we_ff <= 1'b0;
      if (wr_commit && hdr_reg == pxc_pkg::REG_EXT_CTRL) begin
        ovr_we_ff <= wr_data[pxc_pkg::CTL_OVR_WE_BIT];
        scr_test_ff <= wr_data[pxc_pkg::CTL_SCR_TEST_BIT];
        nrzi_ff <= wr_data[pxc_pkg::CTL_NRZI_BIT];
        tx_inval_ff <= wr_data[pxc_pkg::CTL_TX_INVAL_BIT];
        scr_dis_ff <= wr_data[pxc_pkg::CTL_SCR_DIS_BIT];
      end
    end
  end
  assign override_we_out = ovr_we_ff;
  assign scr_test_out = scr_test_ff;
  assign nrzi_sel_out = nrzi_ff;
  assign tx_invalid_en_out = tx_inval_ff;
  assign scr_disable_out = scr_dis_ff;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in)
      np_ff <= pxc_pkg::RST_NP_CODE;
    else if (np_page_valid_in)
      np_ff <= np_code_in;
  end

  // hold highest until read; a new code in the read cycle is kept
  always_ff @(posedge ref_clk_in) begin
    if (rst_in)
      anp_ff <= pxc_pkg::RST_ANP;
    else if (rd_done17)
      anp_ff <= an_progress_in;
    else if (an_progress_in > anp_ff)
      anp_ff <= an_progress_in;
  end

  sequence s_page_seen;
    np_page_valid_in ##1 1'b1;
  endsequence
  property p_np_code;
    @(posedge ref_clk_in) disable iff (rst_in)
      np_page_valid_in |=> np_ff == $past(np_code_in);
  endproperty
  a_np_code: assert property (p_np_code) else $error("next-page code not captured");

  property p_rsv_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
      (rd_load && is_reserved(hdr_reg)) |=> rd_sr_ff == 16'h0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved register read non-zero");

  property p_ovr_sc;
    @(posedge ref_clk_in) disable iff (rst_in)
      override_we_out |=> !override_we_out;
  endproperty
  a_ovr_sc: assert property (p_ovr_sc) else $error("override bit did not self-clear");

  property p_addr;
    @(posedge ref_clk_in) disable iff (rst_in)
      $fell(strap_pend_ff) |-> phy_addr_out == {2'h0, $past(phy_addr_strap_in)} ##1 $stable(phy_addr_out);
  endproperty
  a_addr: assert property (p_addr) else $error("strap address not latched");

  sequence s_ctl_write;
    wr_commit && hdr_reg == pxc_pkg::REG_EXT_CTRL;
  endsequence
  property p_scr_test;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_ctl_write |=> scr_test_out == $past(wr_data[5]);
  endproperty
  a_scr_test: assert property (p_scr_test) else $error("scrambler test bit not written");

  property p_nrzi;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_ctl_write |=> nrzi_sel_out == $past(wr_data[3]);
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("encoding select not written");

  property p_tx_inval;
    @(posedge ref_clk_in) disable iff (rst_in)
      !(wr_commit && hdr_reg == pxc_pkg::REG_EXT_CTRL) |=> $stable(tx_invalid_en_out);
  endproperty
  a_tx_inval: assert property (p_tx_inval) else $error("invalid code enable changed without write");

  property p_scr_dis;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_ctl_write |=> scr_disable_out == $past(wr_data[0]);
  endproperty
  a_scr_dis: assert property (p_scr_dis) else $error("scrambler disable not written");

  property p_status_rate;
    @(posedge ref_clk_in) disable iff (rst_in)
      (rd_load && hdr_reg == pxc_pkg::REG_QP_STATUS) |=>
        rd_sr_ff[15:14] == {$past(speed_100_in), $past(full_duplex_in)};
  endproperty
  a_status_rate: assert property (p_status_rate) else $error("rate or duplex misreported");

  property p_anp_max;
    @(posedge ref_clk_in) disable iff (rst_in)
      !rd_done17 |=> anp_ff >= $past(anp_ff) && anp_ff >= $past(an_progress_in);
  endproperty
  a_anp_max: assert property (p_anp_max) else $error("progress field dropped below maximum");

  property p_anp_clear;
    @(posedge ref_clk_in) disable iff (rst_in)
      rd_done17 |=> anp_ff == $past(an_progress_in);
  endproperty
  a_anp_clear: assert property (p_anp_clear) else $error("progress not resumed after read");

endmodule
`default_nettype wire

// >>> tb/pxc_sta_model.sv
// station management controller model that runs management frames
`timescale 1ns/1ps
`default_nettype none
module pxc_sta_model (
  input wire logic ref_clk_in,   // bench clock
  input wire logic mdio_oe_n_in, // device drive enable, low active
  input wire logic mdio_dev_in,  // device drive value
  output logic mdc_out,          // management clock, still between frames
  output logic mdio_pin_out      // resolved data pin level
);
  logic host_drv;
  logic host_oe;
  // pull-up holds the pin high when nobody drives
  assign mdio_pin_out = !mdio_oe_n_in ? mdio_dev_in : (host_oe ? host_drv : 1'b1);
  initial begin
    mdc_out = 1'b0;
    host_drv = 1'b1;
    host_oe = 1'b0;
  end
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_no,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [63:0] bits;
    if (reg_no == pxc_pkg::REG_EXT_CTRL) wdata = wdata & 16'h87ed;
    bits = {32'hffffffff, 2'b01, op, phy, reg_no, 2'b10, wdata};
    rdata = 16'h0;
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk_in);
      mdc_out <= 1'b0;
      host_drv <= bits[63 - i];
      // released from turnaround on for reads
      host_oe <= !(op == pxc_pkg::OP_READ && i >= 46);
      repeat (5) @(posedge ref_clk_in);
      if (i >= 48) rdata = {rdata[14:0], mdio_pin_out};
      mdc_out <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
    end
    @(posedge ref_clk_in);
    mdc_out <= 1'b0;
    host_oe <= 1'b0;
    repeat (40) @(posedge ref_clk_in);
  endtask
endmodule
`default_nettype wire

// >>> tb/test_phy_ext_control_status_regs.sv
// self-checking bench for the extended control and status register bank
`timescale 1ns/1ps
`default_nettype none
module test_phy_ext_control_status_regs;
  logic ref_clk_in, rst_in, mdc, mdio_pin, mdio_out, mdio_oe_n, np_valid, spd, fdx;
  logic ovr, scr_test, nrzi, tx_inval, scr_dis;
  logic [3:0] np_code, p;
  logic [2:0] strap, anp;
  logic [4:0] phy_addr;
  logic [15:0] rd;
  logic [3:0] pat [4] = '{4'ha, 4'h5, 4'hf, 4'h0};
  int err_count = 0;
  int cmp_count = 0;
  int ovr_cnt = 0;
  int base;
  pxc_ext_regs pxc_ext_regs_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .mdc_in(mdc), .mdio_in(mdio_pin),
    .mdio_out(mdio_out), .mdio_oe_n_out(mdio_oe_n), .np_code_in(np_code),
    .np_page_valid_in(np_valid), .phy_addr_strap_in(strap), .speed_100_in(spd),
    .full_duplex_in(fdx), .an_progress_in(anp), .override_we_out(ovr),
    .scr_test_out(scr_test), .nrzi_sel_out(nrzi), .tx_invalid_en_out(tx_inval),
    .scr_disable_out(scr_dis), .phy_addr_out(phy_addr));
  pxc_sta_model pxc_sta_model_inst (.ref_clk_in(ref_clk_in), .mdio_oe_n_in(mdio_oe_n),
    .mdio_dev_in(mdio_out), .mdc_out(mdc), .mdio_pin_out(mdio_pin));
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  // counts cycles with the override pulse high
  always @(posedge ref_clk_in) if (ovr === 1'b1) ovr_cnt <= ovr_cnt + 1;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_reg(input logic [4:0] r, output logic [15:0] d);
    pxc_sta_model_inst.frame(pxc_pkg::OP_READ, {2'h0, strap}, r, 16'h0, d);
  endtask
  task automatic wr_reg(input logic [4:0] r, input logic [15:0] d);
    logic [15:0] unused;
    pxc_sta_model_inst.frame(pxc_pkg::OP_WRITE, {2'h0, strap}, r, d, unused);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    np_code = 4'h0;
    np_valid = 1'b0;
    strap = 3'h5;
    spd = 1'b0;
    fdx = 1'b0;
    anp = 3'h0;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rd_reg(pxc_pkg::REG_EXT_CTRL, rd);
    check("ctrl reset", rd, 16'h0148);
    check("addr out", {11'h0, phy_addr}, 16'h0005);
    check("ctl outs", {12'h0, scr_test, nrzi, tx_inval, scr_dis}, 16'h0004);
    rd_reg(pxc_pkg::REG_NP_ABILITY, rd);
    check("np reset", rd, 16'h0000);
    $display("test reset done");
    // read-only address bits are set on purpose; the model masks the reserved bits to zero before sending
    for (int i = 0; i < 4; i++) begin
      p = pat[i];
      base = ovr_cnt;
      wr_reg(pxc_pkg::REG_EXT_CTRL, {i == 0, 4'hf, 5'h1f, p[3], 1'b1, p[2:1], 1'b1, p[0]});
      check("ctl outs", {12'h0, scr_test, nrzi, tx_inval, scr_dis}, {12'h0, p});
      check("ovr pulses", 16'(ovr_cnt - base), {15'h0, i == 0});
      rd_reg(pxc_pkg::REG_EXT_CTRL, rd);
      check("ctrl rdback", rd, {5'h0, 5'h05, p[3], 1'b0, p[2:1], 1'b0, p[0]});
    end
    $display("test control writes done");
    @(posedge ref_clk_in);
    np_code <= 4'ha;
    np_valid <= 1'b1;
    @(posedge ref_clk_in);
    np_valid <= 1'b0;
    np_code <= 4'h3;
    rd_reg(pxc_pkg::REG_NP_ABILITY, rd);
    check("np code", rd, 16'h000a);
    for (int r = pxc_pkg::REG_RSV_LO; r <= pxc_pkg::REG_RSV_HI; r++) begin
      wr_reg(5'(r), 16'hffff);
      rd_reg(5'(r), rd);
      check("reserved reg", rd, 16'h0000);
    end
    // foreign address must leave the pin to its pull-up
    pxc_sta_model_inst.frame(pxc_pkg::OP_READ, 5'h06, pxc_pkg::REG_EXT_CTRL, 16'h0, rd);
    check("foreign addr", rd, 16'hffff);
    $display("test page and reserved done");
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_in);
      spd <= i[1];
      fdx <= i[0];
      rd_reg(pxc_pkg::REG_QP_STATUS, rd);
      check("rate duplex", rd, {i[1], i[0], 14'h0});
    end
    @(posedge ref_clk_in);
    anp <= 3'h5;
    repeat (4) @(posedge ref_clk_in);
    anp <= 3'h1;
    rd_reg(pxc_pkg::REG_QP_STATUS, rd);
    check("progress held", rd, 16'he800);
    anp <= 3'h0;
    rd_reg(pxc_pkg::REG_QP_STATUS, rd);
    check("progress reload", rd, 16'hc800);
    rd_reg(pxc_pkg::REG_QP_STATUS, rd);
    check("progress track", rd, 16'hc000);
    $display("test status done");
    wrap_up();
  end
endmodule
`default_nettype wire
